/* rtl/dgp_pkg.sv */
// shared constants for the dual general-purpose port block
package dgp_pkg;
  // avalon byte address width; register byte address is index * 4
  localparam int AW = 10;
  localparam int DW = 32;
  localparam int PA_W = 5;
  localparam int PB_W = 8;

  // register indices
  localparam logic [7:0] IDX_A_DATA = 8'h05;
  localparam logic [7:0] IDX_A_DIR  = 8'h85;
  localparam logic [7:0] IDX_ANCFG  = 8'h9f;
  localparam logic [7:0] IDX_B_DATA = 8'h06;
  localparam logic [7:0] IDX_B_DIR  = 8'h86;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_INTCTL = 8'h0b;
  localparam logic [7:0] IDX_BITOP  = 8'h10;

  // reset values
  localparam logic [5:0] RST_A_DIR  = 6'h3f;
  localparam logic [2:0] RST_ANCFG  = 3'h0;
  localparam logic [7:0] RST_B_DIR  = 8'hff;
  localparam logic [7:0] RST_OPTION = 8'hff;

  // field positions
  localparam int OPT_PU_DIS_N = 7;
  localparam int INT_CHG_FLAG = 0;
  localparam int PA_T0CK      = 4;
  localparam int BOP_VAL      = 3;
  localparam int BOP_PORT_B   = 4;

  // analog pin mask per config code, 4 bits per code, code 0 in the low nibble
  localparam logic [31:0] ANA_MASK = 32'h001337ff;
  // codes that select analog pin 3 as the reference input; this takes effect only while pin 3 is analog
  localparam logic [7:0]  ANA_VREF = 8'h2a;
endpackage

/* rtl/dgp_chg_if.sv */
// carrier between the port logic and the change detector
`timescale 1ns/1ps
`default_nettype none
interface dgp_chg_if;
  logic [3:0] pins;
  logic [3:0] is_in;
  logic       refresh;
  logic       mismatch;
  modport ctl (output pins, output is_in, output refresh, input mismatch);
  modport det (input pins, input is_in, input refresh, output mismatch);
endinterface
`default_nettype wire

/* rtl/dgp_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dgp_sync #(
  parameter int W = 13
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // asynchronous pins in, synchronised levels out
  input  wire logic [W-1:0] pin_a,
  output logic      [W-1:0] pin_s
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dgp_sync_s;

  dgp_sync_s st_q;
  dgp_sync_s st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_a;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_s = st_q.s2;
endmodule
`default_nettype wire

/* rtl/dgp_chg.sv */
// change detector for the upper four pins of the second port
`timescale 1ns/1ps
`default_nettype none
module dgp_chg (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // link to the port logic
  dgp_chg_if.det    cif
);
  typedef struct packed {
    logic [3:0] old;
    logic       mism;
  } dgp_chg_s;

  dgp_chg_s st_q;
  dgp_chg_s st_d;

  always_comb begin
    st_d = st_q;
    if (cif.refresh) begin
      // an access re-arms the compare, ending the mismatch
      st_d.old  = cif.pins;
      st_d.mism = 1'b0;
    end else begin
      st_d.mism = |((cif.pins ^ st_q.old) & cif.is_in);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cif.mismatch = st_q.mism;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_out_excl;
    (cif.is_in == 4'h0) && !cif.refresh |=> !cif.mismatch;
  endproperty
  a_out_excl: assert property (p_out_excl) else $error("output pin caused change");
endmodule
`default_nettype wire

/* rtl/dgp_top.sv */
// dual general-purpose port with change flag, avalon-mm register slave
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module dgp_top (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // avalon-mm slave
  input  wire logic [dgp_pkg::AW-1:0]   avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [dgp_pkg::DW-1:0]   avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [dgp_pkg::DW-1:0]   avs_readdata,
  output logic                          avs_waitrequest,
  // first port pins
  input  wire logic [dgp_pkg::PA_W-1:0] pa_in,
  output logic      [dgp_pkg::PA_W-1:0] pa_out,
  output logic      [dgp_pkg::PA_W-1:0] pa_oe,
  // second port pins
  input  wire logic [dgp_pkg::PB_W-1:0] pb_in,
  output logic      [dgp_pkg::PB_W-1:0] pb_out,
  output logic      [dgp_pkg::PB_W-1:0] pb_oe,
  output logic      [dgp_pkg::PB_W-1:0] pb_pullup,
  // peripheral sharing of second port pins
  input  wire logic [dgp_pkg::PB_W-1:0] periph_en,
  input  wire logic [dgp_pkg::PB_W-1:0] periph_dir,
  input  wire logic [dgp_pkg::PB_W-1:0] periph_out,
  output logic      [dgp_pkg::PB_W-1:0] periph_in,
  // analog, timer and power side
  output logic      [3:0]               analog_sel,
  output logic                          vref_sel,
  output logic                          timer_clk_in,
  input  wire logic                     sleep_i,
  output logic                          wake_o,
  output logic                          port_change_flag
);
  import dgp_pkg::*;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } dgp_bus_e;

  typedef struct packed {
    dgp_bus_e        bus;
    logic            wreq;
    logic [DW-1:0]   rdata;
    logic [5:0]      a_dir;
    logic [PA_W-1:0] a_lat;
    logic [2:0]      ancfg;
    logic [PB_W-1:0] b_dir;
    logic [PB_W-1:0] b_lat;
    logic [PB_W-1:0] option;
    logic            chg_flag;
    logic [PA_W-1:0] pa_out;
    logic [PA_W-1:0] pa_oe;
    logic [PB_W-1:0] pb_out;
    logic [PB_W-1:0] pb_oe;
    logic [PB_W-1:0] pb_pu;
    logic [PB_W-1:0] per_in;
    logic [3:0]      ana;
    logic            vref;
    logic            t0clk;
    logic            wake;
  } dgp_top_s;

  localparam dgp_top_s ST_RST = '{
    bus:      BUS_IDLE,
    wreq:     1'b1,
    rdata:    '0,
    a_dir:    RST_A_DIR,
    a_lat:    '0,
    ancfg:    RST_ANCFG,
    b_dir:    RST_B_DIR,
    b_lat:    '0,
    option:   RST_OPTION,
    chg_flag: 1'b0,
    pa_out:   '0,
    pa_oe:    '0,
    pb_out:   '0,
    pb_oe:    '0,
    pb_pu:    '0,
    per_in:   '0,
    ana:      4'hf,
    vref:     1'b0,
    t0clk:    1'b0,
    wake:     1'b0
  };

  dgp_top_s st_q;
  dgp_top_s st_d;

  logic [PA_W+PB_W-1:0] pin_s;
  logic [PA_W-1:0]      a_sync;
  logic [PB_W-1:0]      b_sync;
  logic [7:0]           a_idx;
  logic                 acc;
  logic                 accept;
  logic                 done;
  logic [3:0]           ana_mask;
  logic [PA_W-1:0]      a_rd;
  logic [PB_W-1:0]      b_dir_e;
  logic [PB_W-1:0]      b_drv;
  logic                 refresh;

  dgp_chg_if cif ();

  dgp_sync #(
    .W (PA_W + PB_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_a   ({pb_in, pa_in}),
    .pin_s   (pin_s)
  );

  dgp_chg u_chg (
    .ref_clk (ref_clk),
    .rst     (rst),
    .cif     (cif.det)
  );

  assign a_sync   = pin_s[PA_W-1:0];
  assign b_sync   = pin_s[PA_W+PB_W-1:PA_W];
  assign a_idx    = avs_address[AW-1:2];
  assign acc      = avs_read | avs_write;
  assign accept   = acc & st_q.wreq;
  assign done     = acc & ~st_q.wreq;
  assign ana_mask = ANA_MASK[st_q.ancfg*4 +: 4];
  // analog pins read as zero on the digital path
  assign a_rd     = a_sync & {1'b1, ~ana_mask};
  // an enabled peripheral owns direction and drive of its pin
  assign b_dir_e  = (periph_en & periph_dir) | (~periph_en & st_q.b_dir);
  assign b_drv    = (periph_en & periph_out) | (~periph_en & st_q.b_lat);

  // reads and writes of the second port, bit ops on it too, re-arm the compare
  assign refresh = (accept & (a_idx == IDX_B_DATA))
                 | (done & avs_write & (a_idx == IDX_BITOP)
                    & avs_writedata[BOP_PORT_B]);

  assign cif.pins    = b_sync[7:4];
  assign cif.is_in   = b_dir_e[7:4];
  assign cif.refresh = refresh;

  always_comb begin
    st_d      = st_q;
    st_d.wreq = 1'b1;
    st_d.bus  = BUS_IDLE;
    // one wait cycle: request seen, then answered on the next edge
    if (accept) begin
      st_d.wreq = 1'b0;
      st_d.bus  = BUS_ACK;
      st_d.rdata = '0;
      case (a_idx)
        IDX_A_DATA: st_d.rdata[PA_W-1:0] = a_rd;
        IDX_A_DIR:  st_d.rdata[5:0] = st_q.a_dir;
        IDX_ANCFG:  st_d.rdata[2:0] = st_q.ancfg;
        IDX_B_DATA: st_d.rdata[PB_W-1:0] = b_sync;
        IDX_B_DIR:  st_d.rdata[PB_W-1:0] = st_q.b_dir;
        IDX_OPTION: st_d.rdata[7:0] = st_q.option;
        IDX_INTCTL: st_d.rdata[INT_CHG_FLAG] = st_q.chg_flag;
        default:    st_d.rdata = '0;
      endcase
    end
    // writes land only on the completing edge, low byte lane only
    if (done && avs_write && avs_byteenable[0]) begin
      case (a_idx)
        IDX_A_DATA: st_d.a_lat  = avs_writedata[PA_W-1:0];
        IDX_A_DIR:  st_d.a_dir  = avs_writedata[5:0];
        IDX_ANCFG:  st_d.ancfg  = avs_writedata[2:0];
        IDX_B_DATA: st_d.b_lat  = avs_writedata[PB_W-1:0];
        IDX_B_DIR:  st_d.b_dir  = avs_writedata[PB_W-1:0];
        IDX_OPTION: st_d.option = avs_writedata[7:0];
        IDX_INTCTL: begin
          if (!avs_writedata[INT_CHG_FLAG]) begin
            st_d.chg_flag = 1'b0;
          end
        end
        IDX_BITOP: begin
          // pins are sampled, one bit changed, the whole byte latched
          if (avs_writedata[BOP_PORT_B]) begin
            st_d.b_lat = b_sync;
            st_d.b_lat[avs_writedata[2:0]] = avs_writedata[BOP_VAL];
          end else if (avs_writedata[2:0] < 3'(PA_W)) begin
            st_d.a_lat = a_rd;
            st_d.a_lat[avs_writedata[2:0]] = avs_writedata[BOP_VAL];
          end
        end
        default: begin
        end
      endcase
    end
    // set wins over a clear in the same cycle
    if (cif.mismatch) begin
      st_d.chg_flag = 1'b1;
    end
    // first port: direction holds even on analog pins
    st_d.pa_oe[3:0]  = ~st_q.a_dir[3:0];
    st_d.pa_out[3:0] = st_q.a_lat[3:0];
    // open drain: only ever pulls low
    st_d.pa_oe[PA_T0CK]  = ~st_q.a_dir[PA_T0CK] & ~st_q.a_lat[PA_T0CK];
    st_d.pa_out[PA_T0CK] = 1'b0;
    st_d.t0clk = a_sync[PA_T0CK];
    st_d.ana   = ana_mask;
    st_d.vref  = ANA_VREF[st_q.ancfg] & ana_mask[3];
    // second port
    st_d.pb_oe  = ~b_dir_e;
    st_d.pb_out = b_drv;
    st_d.pb_pu  = {PB_W{~st_q.option[OPT_PU_DIS_N]}} & b_dir_e;
    st_d.per_in = b_sync & periph_en;
    st_d.wake   = sleep_i & cif.mismatch;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata     = st_q.rdata;
  assign avs_waitrequest  = st_q.wreq;
  assign pa_out           = st_q.pa_out;
  assign pa_oe            = st_q.pa_oe;
  assign pb_out           = st_q.pb_out;
  assign pb_oe            = st_q.pb_oe;
  assign pb_pullup        = st_q.pb_pu;
  assign periph_in        = st_q.per_in;
  assign analog_sel       = st_q.ana;
  assign vref_sel         = st_q.vref;
  assign timer_clk_in     = st_q.t0clk;
  assign wake_o           = st_q.wake;
  assign port_change_flag = st_q.chg_flag;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_dir_a;
    !st_q.a_dir[0] |=> pa_oe[0] && (pa_out[0] == $past(st_q.a_lat[0]));
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("first port pin not driven");

  property p_rd_a;
    accept && avs_read && (a_idx == IDX_A_DATA) |=> avs_readdata[4:0] == $past(a_rd);
  endproperty
  a_rd_a: assert property (p_rd_a) else $error("first port read not pins");

  property p_od;
    pa_oe[PA_T0CK] |-> !pa_out[PA_T0CK] && !$past(st_q.a_lat[PA_T0CK]);
  endproperty
  a_od: assert property (p_od) else $error("open drain drove high");

  property p_ana_rd;
    accept && avs_read && (a_idx == IDX_A_DATA) && ana_mask[0] |=> !avs_readdata[0];
  endproperty
  a_ana_rd: assert property (p_ana_rd) else $error("analog pin read nonzero");

  property p_rst_ana;
    $fell(rst) |-> analog_sel == 4'hf && pb_pullup == 8'h00;
  endproperty
  a_rst_ana: assert property (p_rst_ana) else $error("reset state wrong");

  property p_pu_out;
    (pb_pullup & pb_oe) == 8'h00;
  endproperty
  a_pu_out: assert property (p_pu_out) else $error("pull-up on output");

  property p_pu_ctl;
    st_q.option[OPT_PU_DIS_N] |=> pb_pullup == 8'h00;
  endproperty
  a_pu_ctl: assert property (p_pu_ctl) else $error("pull-up while disabled");

  property p_ovr;
    periph_en[1] && !periph_dir[1] |=> pb_oe[1] && (pb_out[1] == $past(periph_out[1]));
  endproperty
  a_ovr: assert property (p_ovr) else $error("peripheral override lost");

  property p_flag;
    cif.mismatch |=> port_change_flag ##1 port_change_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("change flag not set");

  property p_wake;
    sleep_i && cif.mismatch |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on change");

  property p_bus;
    accept |=> (st_q.bus == BUS_ACK) && !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer timing wrong");

  property p_clr;
    done && avs_write && avs_byteenable[0] && (a_idx == IDX_INTCTL)
      && !avs_writedata[INT_CHG_FLAG] && !cif.mismatch |=> !port_change_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("change flag not cleared");

  property p_pu_on;
    !st_q.option[OPT_PU_DIS_N] |=> pb_pullup == $past(b_dir_e);
  endproperty
  a_pu_on: assert property (p_pu_on) else $error("pull-up not enabled on input");

  property p_vref;
    vref_sel |-> analog_sel[3];
  endproperty
  a_vref: assert property (p_vref) else $error("reference on digital pin");

  c_rd_b: cover property (accept && avs_read && (a_idx == IDX_B_DATA));
  c_flag: cover property ($rose(port_change_flag));
  c_bitop: cover property (done && avs_write && (a_idx == IDX_BITOP));
  c_wake: cover property (wake_o);
  c_ovr: cover property (periph_en[1] && !periph_dir[1]);
endmodule
`default_nettype wire

/* verif/dgp_pins.sv */
// board-side pin model: external drivers, pull-ups and floating lines
`timescale 1ns/1ps
`default_nettype none
module dgp_pins (
  // device side
  input  wire logic       ref_clk,
  input  wire logic [4:0] pa_out,
  input  wire logic [4:0] pa_oe,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] pb_pullup,
  // board drivers and resolved levels
  input  wire logic [4:0] xa,
  input  wire logic [4:0] xa_en,
  input  wire logic [7:0] xb,
  input  wire logic [7:0] xb_en,
  output logic      [4:0] pa_lvl,
  output logic      [7:0] pb_lvl
);
  logic [12:0] last_q = '0;
  // an undriven line without pull-up flips every cycle, so a stale value never passes
  assign pa_lvl = pa_oe & pa_out | ~pa_oe & (xa_en & xa | ~xa_en & ~last_q[4:0]);
  assign pb_lvl = pb_oe & pb_out
    | ~pb_oe & (xb_en & xb | ~xb_en & (pb_pullup | ~last_q[12:5]));
  always @(posedge ref_clk) last_q <= {pb_lvl, pa_lvl};
endmodule
`default_nettype wire

/* verif/dgp_top_bench.sv */
// self-checking bench: dual port block against a reference model
`timescale 1ns/1ps
`default_nettype none
module dgp_top_bench;
  import dgp_pkg::*;
  logic          ref_clk = 1'b0;
  logic          rst = 1'b1;
  logic [AW-1:0] adr = '0;
  logic          rd_s = 1'b0;
  logic          wr_s = 1'b0;
  logic [DW-1:0] wdat = '0;
  logic [DW-1:0] rdat;
  logic          wait_s;
  logic [4:0]    pa_in, pa_out, pa_oe, xa = '0, xa_en = '1;
  logic [7:0]    pb_in, pb_out, pb_oe, pb_pu, p_in, xb = '0, xb_en = '1;
  logic [7:0]    pe = '0, pdir = '0, pout = '0;
  logic [3:0]    an_sel;
  logic [3:0]    be = 4'hf;
  logic          vref, tclk, wake, chg, slp = 1'b0;
  logic [31:0]   r;
  int            err_total = 0, checks_done = 0, seed_v;
  int            a_lat = 0, a_dir = 63, ancfg = 0, b_lat = 0, b_dir = 255, opt = 255;
  int            cmp = 0, flag = 0;

  always #12.5 ref_clk = ~ref_clk;

  dgp_top u_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_s), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pu), .periph_en(pe), .periph_dir(pdir),
    .periph_out(pout), .periph_in(p_in), .analog_sel(an_sel), .vref_sel(vref),
    .timer_clk_in(tclk), .sleep_i(slp), .wake_o(wake), .port_change_flag(chg));
  dgp_pins u_pins (.ref_clk(ref_clk), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
    .pb_oe(pb_oe), .pb_pullup(pb_pu), .xa(xa), .xa_en(xa_en), .xb(xb), .xb_en(xb_en),
    .pa_lvl(pa_in), .pb_lvl(pb_in));

  function automatic int am();
    return int'(ANA_MASK >> 4 * ancfg) & 15;
  endfunction
  function automatic int aoe();
    return ~a_dir & ~(a_lat & 16) & 31;
  endfunction
  function automatic int ard();
    return (aoe() & a_lat | ~aoe() & xa) & ~am() & 31;
  endfunction
  function automatic int bde();
    return (pe & pdir | ~pe & b_dir) & 255;
  endfunction
  function automatic int bpin();
    return ~bde() & (pe & pout | ~pe & b_lat)
      | bde() & (xb_en & xb | ~xb_en & (opt & 128 ? 0 : 255));
  endfunction
  function automatic bit mism();
    return ((bpin() ^ cmp) & bde() & 240) != 0;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    if (mism()) flag = 1;
  endtask
  // request held until the edge that sees waitrequest low
  task automatic bus(input bit w, input int idx, input int d);
    int n;
    n = 0;
    adr <= AW'(idx * 4);
    wdat <= DW'(d);
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 40) begin
        err_total++;
        test_done();
      end
    end while (wait_s !== 1'b0);
    r = rdat;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    tk(6);
  endtask
  task automatic wr(input int idx, input int d);
    int p;
    p = 1 << (d & 7);
    if (idx == IDX_B_DATA || idx == IDX_BITOP && d & 16) cmp = bpin();
    case (idx)
      IDX_A_DATA: a_lat = d & 31;
      IDX_A_DIR: a_dir = d & 63;
      IDX_ANCFG: ancfg = d & 7;
      IDX_B_DATA: b_lat = d & 255;
      IDX_B_DIR: b_dir = d & 255;
      IDX_OPTION: opt = d & 255;
      IDX_BITOP: if (d & 16) b_lat = bpin() & ~p | (d & 8 ? p : 0);
        else a_lat = (ard() & ~p | (d & 8 ? p : 0)) & 31;
      default: ;
    endcase
    bus(1'b1, idx, d);
    if (idx == IDX_INTCTL && !(d & 1)) flag = mism();
  endtask
  task automatic rd(input int idx, input int want);
    if (idx == IDX_B_DATA) cmp = bpin();
    bus(1'b0, idx, 0);
    chk(r, want);
  endtask
  task automatic pins();
    chk(pa_oe, aoe());
    chk(pa_out & pa_oe, a_lat & aoe());
    chk(pb_oe, ~bde() & 255);
    chk(pb_out & pb_oe, bpin() & ~bde() & 255);
    chk(pb_pu, opt & 128 ? 0 : bde());
    chk(p_in, bpin() & pe);
    chk(an_sel, am());
    chk(vref, ANA_VREF[ancfg] & am() >> 3);
    chk(tclk, xa[4] & !(aoe() & 16));
    chk(wake, slp & mism());
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    err_total++;
    test_done();
  end

  initial begin
    seed_v = $urandom(32'hb4f7);
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    xa <= 5'h1f;
    tk(4);
    pins();
    rd(IDX_A_DIR, 63);
    rd(IDX_ANCFG, 0);
    rd(IDX_B_DIR, 255);
    rd(IDX_OPTION, 255);
    rd(IDX_INTCTL, 0);
    rd(IDX_A_DATA, 16);
    $display("test 1 done");
    for (int c = 0; c < 8; c++) begin
      wr(IDX_ANCFG, c);
      xa <= 5'($urandom);
      tk(4);
      pins();
      rd(IDX_A_DATA, ard());
    end
    $display("test 2 done");
    for (int i = 0; i < 10; i++) begin
      wr(IDX_ANCFG, $urandom & 7);
      // analog pins keep their direction bits set
      wr(IDX_A_DIR, $urandom & 63 | am());
      wr(IDX_A_DATA, $urandom & 255);
      xa <= 5'($urandom);
      tk(4);
      pins();
      rd(IDX_A_DATA, ard());
      wr(IDX_BITOP, $urandom % 5 | $urandom & 8);
      pins();
    end
    wr(8'h33, 255);
    rd(8'h33, 0);
    // low byte lane off: the write must be ignored
    be <= 4'he;
    bus(1'b1, IDX_A_DIR, 0);
    be <= 4'hf;
    rd(IDX_A_DIR, a_dir);
    $display("test 3 done");
    for (int i = 0; i < 10; i++) begin
      pe <= 8'($urandom);
      pdir <= 8'($urandom);
      pout <= 8'($urandom);
      xb <= 8'($urandom);
      wr(IDX_OPTION, $urandom & 255);
      wr(IDX_B_DIR, $urandom & 255);
      wr(IDX_B_DATA, $urandom & 255);
      pins();
      wr(IDX_BITOP, 16 | $urandom & 15);
      pins();
      rd(IDX_B_DATA, bpin());
      wr(IDX_INTCTL, 0);
      rd(IDX_INTCTL, flag);
    end
    $display("test 4 done");
    pe <= '0;
    wr(IDX_OPTION, 8'h7f);
    wr(IDX_B_DIR, 8'h0f);
    xb_en <= '0;
    tk(4);
    pins();
    rd(IDX_B_DATA, bpin());
    xb_en <= '1;
    xb <= 8'h5a;
    $display("test 5 done");
    wr(IDX_B_DIR, 255);
    slp <= 1'b1;
    rd(IDX_B_DATA, 8'h5a);
    wr(IDX_INTCTL, 0);
    for (int i = 0; i < 8; i++) begin
      xb <= xb ^ 8'(1 << i);
      tk(5);
      chk(chg, i > 3);
      chk(wake, i > 3);
      wr(IDX_INTCTL, 0);
      rd(IDX_INTCTL, i > 3);
      if (i % 2) rd(IDX_B_DATA, bpin());
      else wr(IDX_B_DATA, 0);
      wr(IDX_INTCTL, 0);
      chk(chg, 0);
    end
    wr(IDX_B_DATA, ~xb & 255);
    wr(IDX_B_DIR, 8'h7f);
    tk(4);
    chk(chg, 0);
    pins();
    $display("test 6 done");
    test_done();
  end
endmodule
`default_nettype wire
